// ---- include/intc_pkg.sv ----
package intc_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_SRC       = 62;
    localparam int NUM_PRIO_REGS = 10;
    localparam int SRC_IDX_W     = 6;
    localparam int VEC_W         = 8;
    localparam int LVL_W         = 5;
    localparam int MASK_W        = 4;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;
    localparam int PRIO_W        = 16;
    localparam int TBL_ADDR_W    = 10;
    localparam int NUM_EVT       = 3;

    // ==========================================================
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_PRIO_A  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PRIO_J  = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR   = 8'h2c;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE  = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_SELECT  = 8'h34;

    // event bit positions
    localparam int EVT_ACCEPT  = 0;
    localparam int EVT_BLOCKED = 1;
    localparam int EVT_NMI     = 2;

    // ==========================================================
    // levels and special field codes
    localparam logic [LVL_W-1:0]     LVL_ZERO    = 5'h00;
    localparam logic [LVL_W-1:0]     LVL_NMI     = 5'h10;
    localparam logic [LVL_W-1:0]     LVL_FIXED   = 5'h0f;
    localparam logic [SRC_IDX_W-1:0] FLD_NMI     = 6'h28;
    localparam logic [SRC_IDX_W-1:0] FLD_FIXED15 = 6'h29;
    localparam logic [PRIO_W-1:0]    PRIO_RESET  = 16'h0000;
    localparam int                   NMI_IDX     = 0;

    // ==========================================================
    // source table, index order is the default priority order
    localparam logic [VEC_W-1:0] SRC_VEC [NUM_SRC] = '{
        8'h0b, 8'h0c, 8'h0e,
        8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
        8'h48, 8'h4c, 8'h50, 8'h54,
        8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c,
        8'h60, 8'h61, 8'h64, 8'h65,
        8'h68, 8'h69, 8'h6c, 8'h6d,
        8'h70, 8'h71, 8'h72, 8'h73, 8'h74,
        8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
        8'h80, 8'h81, 8'h82, 8'h83,
        8'h84, 8'h85, 8'h86, 8'h87,
        8'h88, 8'h89, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c,
        8'ha8, 8'ha9, 8'haa, 8'hab,
        8'hac, 8'had, 8'hae, 8'haf,
        8'hc0
    };

    // priority field: register index times four plus nibble (0 = top nibble)
    localparam logic [SRC_IDX_W-1:0] SRC_FLD [NUM_SRC] = '{
        6'h28, 6'h29, 6'h29,
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
        6'h08, 6'h09, 6'h0a, 6'h0b,
        6'h0c, 6'h0c, 6'h0c, 6'h0c, 6'h0d,
        6'h0e, 6'h0e, 6'h0f, 6'h0f,
        6'h10, 6'h10, 6'h11, 6'h11,
        6'h12, 6'h12, 6'h12, 6'h12, 6'h13,
        6'h14, 6'h14, 6'h14, 6'h14, 6'h15,
        6'h16, 6'h16, 6'h16, 6'h16,
        6'h17, 6'h17, 6'h17, 6'h17,
        6'h18, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d,
        6'h20, 6'h20, 6'h20, 6'h20,
        6'h21, 6'h21, 6'h21, 6'h21,
        6'h26
    };

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic                  valid;
        logic [VEC_W-1:0]      vector;
        logic [LVL_W-1:0]      level;
        logic [TBL_ADDR_W-1:0] table_addr;
    } cpu_req_s;

endpackage

// ---- src/interrupt_vector_priority_resolver.sv ----
// Functional notes
// - every source owns a distinct vector number and table offset
// - the accepted request carries its vector so the cpu fetches the handler
// - pins and peripheral groups have four-bit software levels 0 to 15
// - sources sharing one field rank by smaller vector number first, fixed
// - reset clears every programmable level to zero
// - equal levels resolve by fixed default order, earlier entries win
// - nmi vector 11 fixed top level; user break 12, debug request 14
// - pins 0..7 use vectors 64..71, nibbles from top of register a into b
// - dma ends use 72,76,80,84 with register c nibbles, channel 0 top
// - timer 0 compares 88..91 share a field; overflow 92 has its own
// - serial 0 requests 128..131 share one level field
// - transfer end 140 own field; a/d 136,137 share; compare timer 144,148
// - watchdog 152 own field; output enable 156 separate field
// - two-wire bus request 192 uses register j middle-low nibble
// - reserved vectors are never produced
// - a level of zero masks the source
// - forward only when level exceeds the cpu mask level
module interrupt_vector_priority_resolver
    import intc_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_sys_rst,
    input  wire intc_pkg::reg_req_s            i_bus,
    output logic [intc_pkg::DATA_W-1:0]        o_rdata,
    input  wire logic [intc_pkg::NUM_SRC-1:0]  i_req,
    input  wire logic [intc_pkg::MASK_W-1:0]   i_cpu_mask_level,
    input  wire logic                          i_cpu_ack,
    output intc_pkg::cpu_req_s                 o_cpu,
    output logic                               o_irq
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [NUM_PRIO_REGS-1:0][PRIO_W-1:0] prio;
        logic [NUM_EVT-1:0]                   status;
        logic [NUM_EVT-1:0]                   enable;
        logic [DATA_W-1:0]                    rdata;
        cpu_req_s                             cpu;
    } state_s;

    state_s state_q;
    state_s state_d;

    // ==========================================================
    // level lookup
    function automatic logic [LVL_W-1:0] src_level(
        input logic [NUM_PRIO_REGS-1:0][PRIO_W-1:0] prio,
        input int                                   idx
    );
        logic [SRC_IDX_W-1:0] fld;
        logic [PRIO_W-1:0]    word;
        logic [1:0]           rev;
        fld  = SRC_FLD[idx];
        word = PRIO_RESET;
        rev  = 2'h3 - fld[1:0];
        if (fld == FLD_NMI)
        begin
            src_level = LVL_NMI;
        end
        else if (fld == FLD_FIXED15)
        begin
            src_level = LVL_FIXED;
        end
        else
        begin
            word      = prio[fld[SRC_IDX_W-1:2]];
            src_level = {1'b0, 4'(word >> {rev, 2'h0})};
        end
    endfunction

    // ==========================================================
    // resolver
    logic [LVL_W-1:0]     best_lvl;
    logic [SRC_IDX_W-1:0] best_idx;
    logic                 found;
    logic                 forward;
    logic [LVL_W-1:0]     lvl;

    always_comb
    begin
        best_lvl = LVL_ZERO;
        best_idx = '0;
        found    = 1'b0;
        lvl      = LVL_ZERO;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            lvl = src_level(state_q.prio, i);
            // strict compare keeps the earlier (smaller vector) entry on ties
            if (i_req[i] && (lvl != LVL_ZERO) && (lvl > best_lvl))
            begin
                best_lvl = lvl;
                best_idx = SRC_IDX_W'(i);
                found    = 1'b1;
            end
        end
        forward = found && (best_lvl > {1'b0, i_cpu_mask_level});
    end

    // ==========================================================
    // register bus decode
    logic                    wr_prio;
    logic [3:0]              prio_sel;
    logic [NUM_EVT-1:0]      clear_bits;
    logic [NUM_EVT-1:0]      events;
    logic [DATA_W-1:0]       rd_value;

    always_comb
    begin
        prio_sel   = i_bus.addr[5:2];
        wr_prio    = i_bus.wr && (i_bus.addr <= ADDR_PRIO_J) && (i_bus.addr[1:0] == 2'h0);
        clear_bits = '0;
        if (i_bus.wr && (i_bus.addr == ADDR_CLEAR))
        begin
            clear_bits = i_bus.wdata[NUM_EVT-1:0];
        end
        events              = '0;
        events[EVT_ACCEPT]  = i_cpu_ack && state_q.cpu.valid;
        events[EVT_BLOCKED] = found && !forward;
        events[EVT_NMI]     = i_req[NMI_IDX];
        rd_value = '0;
        if ((i_bus.addr <= ADDR_PRIO_J) && (i_bus.addr[1:0] == 2'h0))
        begin
            rd_value[PRIO_W-1:0] = state_q.prio[prio_sel];
        end
        else if (i_bus.addr == ADDR_STATUS)
        begin
            rd_value[NUM_EVT-1:0] = state_q.status;
        end
        else if (i_bus.addr == ADDR_ENABLE)
        begin
            rd_value[NUM_EVT-1:0] = state_q.enable;
        end
        else if (i_bus.addr == ADDR_SELECT)
        begin
            rd_value[VEC_W-1:0]             = SRC_VEC[best_idx];
            rd_value[VEC_W +: LVL_W]        = best_lvl;
            rd_value[VEC_W + LVL_W]         = found;
        end
    end

    // ==========================================================
    // next state
    always_comb
    begin
        state_d = state_q;
        if (wr_prio)
        begin
            state_d.prio[prio_sel] = i_bus.wdata[PRIO_W-1:0];
        end
        if (i_bus.wr && (i_bus.addr == ADDR_ENABLE))
        begin
            state_d.enable = i_bus.wdata[NUM_EVT-1:0];
        end
        // a new event wins over a clear in the same cycle
        state_d.status = (state_q.status & ~clear_bits) | events;
        state_d.rdata  = i_bus.rd ? rd_value : '0;
        // only table vectors are ever presented, reserved numbers never
        state_d.cpu.valid      = forward;
        state_d.cpu.vector     = SRC_VEC[best_idx];
        state_d.cpu.level      = best_lvl;
        state_d.cpu.table_addr = {2'h0, SRC_VEC[best_idx]} << 2;
        if (i_sys_rst)
        begin
            state_d = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        state_q <= state_d;
    end

    // ==========================================================
    // outputs
    assign o_rdata = state_q.rdata;
    assign o_cpu   = state_q.cpu;
    assign o_irq   = |(state_q.status & state_q.enable);

endmodule

// ---- tb/cpu_model.sv ----
module cpu_model
    import intc_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire intc_pkg::cpu_req_s i_cpu,
    input  wire logic [3:0]         i_wait,
    input  wire logic [3:0]         i_base,
    output logic                    o_ack = 1'b0,
    output logic [3:0]              o_mask = 4'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    // ==========================================
    // take a request after i_wait cycles, then raise the mask to its level
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        cnt_q <= 4'h0;
        if (i_sys_rst || !i_cpu.valid)
            o_mask <= i_base;
        else if (cnt_q == i_wait && !o_ack)
        begin
            o_ack <= 1'b1;
            o_mask <= (i_cpu.level > 5'h0f) ? 4'hf : i_cpu.level[3:0];
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ---- tb/interrupt_vector_priority_resolver_checker.sv ----
module intc_checker
    import intc_pkg::*;
(
    input wire logic                          i_clk,
    input wire logic                          i_sys_rst,
    input wire intc_pkg::reg_req_s            i_bus,
    input wire logic [intc_pkg::DATA_W-1:0]   o_rdata,
    input wire logic [intc_pkg::NUM_SRC-1:0]  i_req,
    input wire logic [intc_pkg::MASK_W-1:0]   i_cpu_mask_level,
    input wire logic                          i_cpu_ack,
    input wire intc_pkg::cpu_req_s            o_cpu,
    input wire logic                          o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================
    // resolver output
    a_table_addr: assert property (
        o_cpu.valid |-> o_cpu.table_addr == {o_cpu.vector, 2'b00})
        else $error("bad table address");
    a_above_mask: assert property (
        o_cpu.valid |-> o_cpu.level > {1'b0, $past(i_cpu_mask_level)})
        else $error("level not above mask");
    a_valid_cause: assert property (
        o_cpu.valid |-> $past(i_req) != '0) else $error("valid without request");
    a_level_zero: assert property (
        o_cpu.valid |-> o_cpu.level != 5'h00) else $error("level zero forwarded");
    a_nmi_first: assert property (
        i_req[0] |=> o_cpu.valid && o_cpu.vector == 8'h0b && o_cpu.level == 5'h10)
        else $error("nmi not selected");
    a_break_first: assert property (
        !i_req[0] && i_req[1] && i_cpu_mask_level != 4'hf |=> o_cpu.vector == 8'h0c)
        else $error("user break not selected");
    a_mask_full: assert property (
        !i_req[0] && i_cpu_mask_level == 4'hf |=> !o_cpu.valid) else $error("full mask passed");
    a_no_reserved: assert property (
        o_cpu.valid |-> !(o_cpu.vector inside {8'h0f, 8'h99, [8'ha0:8'ha7], [8'hb0:8'hbc],
        [8'hc4:8'hf7]})) else $error("reserved vector");
endmodule

bind interrupt_vector_priority_resolver intc_checker u_intc_checker (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_req(i_req),
    .i_cpu_mask_level(i_cpu_mask_level), .i_cpu_ack(i_cpu_ack), .o_cpu(o_cpu), .o_irq(o_irq));

// ---- tb/interrupt_vector_priority_resolver_tb.sv ----
module interrupt_vector_priority_resolver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import intc_pkg::*;
    localparam int BITS [22] = '{3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 19, 38, 46, 48,
        49, 50, 51, 52, 61};
    localparam int VECS [22] = '{64, 65, 66, 67, 68, 69, 70, 71, 72, 76, 80, 84, 88, 92, 128,
        136, 140, 144, 148, 152, 156, 192};
    localparam int MB [4] = '{14, 15, 1, 0};
    localparam int MR [4] = '{4, 4, 3, 3};
    localparam int MV [4] = '{1, 0, 0, 1};
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    reg_req_s    bus = '0;
    logic [31:0] rdata;
    logic [61:0] req = '0;
    logic [3:0]  mask;
    logic        ack;
    cpu_req_s    cpu;
    logic        irq;
    logic [3:0]  base = 4'h0;
    logic [3:0]  delay = 4'hf;
    logic [31:0] d;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cycles = 0;

    interrupt_vector_priority_resolver u_interrupt_vector_priority_resolver (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata), .i_req(req),
        .i_cpu_mask_level(mask), .i_cpu_ack(ack), .o_cpu(cpu), .o_irq(irq));
    cpu_model u_cpu_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cpu(cpu), .i_wait(delay),
        .i_base(base), .o_ack(ack), .o_mask(mask));

    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus <= '0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus <= '0;
        #1 d = rdata;
        @(posedge i_clk);
    endtask
    task automatic pose(input logic [61:0] r);
        req <= '0;
        repeat (2) @(posedge i_clk);
        req <= r;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic vec(input int b, input int v, input int l);
        pose(62'h1 << b);
        chk("valid", cpu.valid, 1);
        chk("vector", cpu.vector, v);
        chk("table", cpu.table_addr, v * 4);
        chk("level", cpu.level, l);
        @(posedge i_clk);
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // clock, timeout and tests
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        for (int i = 0; i < 16; i++)
        begin
            rd(8'(4 * i));
            // with nothing pending the select word still names the first table entry
            chk("reset read", d, (8'(4 * i) == ADDR_SELECT) ? {24'h0, SRC_VEC[NMI_IDX]} : 32'h0);
        end
        pose(62'h8);
        chk("zero level", cpu.valid, 0);
        @(posedge i_clk);
        for (int i = 0; i < 10; i++)
            wr(8'(4 * i), 32'hffffffff);
        rd(8'h08);
        chk("prio c", d, 32'hffff);
        for (int i = 0; i < 22; i++)
            vec(BITS[i], VECS[i], 15);
        vec(0, 11, 16);
        vec(1, 12, 15);
        vec(2, 14, 15);
        $display("test vectors done");
        pose(62'h3 << 40);
        chk("shared field", cpu.vector, 130);
        @(posedge i_clk);
        rd(ADDR_SELECT);
        chk("select word", d, 32'h00002f82);
        pose(62'h8 | (62'h1 << 61));
        chk("equal levels", cpu.vector, 64);
        @(posedge i_clk);
        wr(8'h00, 32'h1fff);
        pose(62'h8 | (62'h1 << 61));
        chk("higher level", cpu.vector, 192);
        @(posedge i_clk);
        wr(8'h24, 32'hff0f);
        pose(62'h1 << 61);
        chk("bus nibble", cpu.valid, 0);
        @(posedge i_clk);
        for (int i = 0; i < 4; i++)
        begin
            base <= MB[i];
            pose(62'h1 << MR[i]);
            chk("cpu mask", cpu.valid, MV[i]);
            @(posedge i_clk);
        end
        $display("test priority done");
        pose('0);
        @(posedge i_clk);
        wr(ADDR_CLEAR, 32'h7);
        rd(ADDR_STATUS);
        chk("status clear", d, 0);
        base <= 4'hf;
        pose(62'h10);
        chk("irq disabled", irq, 0);
        @(posedge i_clk);
        wr(ADDR_ENABLE, 32'h2);
        chk("irq raised", irq, 1);
        rd(ADDR_STATUS);
        chk("status blocked", d, 2);
        req <= '0;
        @(posedge i_clk);
        wr(ADDR_CLEAR, 32'h2);
        chk("irq cleared", irq, 0);
        base <= 4'h0;
        delay <= 4'h1;
        pose(62'h10);
        repeat (6) @(posedge i_clk);
        rd(ADDR_STATUS);
        chk("accepted", d[0], 1);
        pose(62'h1);
        @(posedge i_clk);
        rd(ADDR_STATUS);
        chk("nmi seen", d[2], 1);
        $display("test interrupt done");
        conclude();
    end
endmodule
